// >>> verilog/pcu_power_control_unit.sv
`timescale 1ns/100ps
module pcu_power_control_unit (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  // Raw activity sources.
  input  wire logic [7:0]                sys_event_i,
  input  wire logic [7:0]                sys_event_mask_i,
  input  wire logic [3:0]                hkp_event_i,
  input  wire logic                      disk_act_i,
  input  wire logic                      serial_act_i,
  input  wire logic                      parallel_act_i,
  // Timer periods and enables.
  input  wire logic [pcu_pkg::TMR_W-1:0] doze_period_i,
  input  wire logic [pcu_pkg::TMR_W-1:0] standby_period_i,
  input  wire logic [pcu_pkg::TMR_W-1:0] suspend_period_i,
  input  wire logic [pcu_pkg::TMR_W-1:0] hkp_period_i,
  input  wire logic [pcu_pkg::TMR_W-1:0] peri_period_i,
  input  wire logic [4:0]                tmr_enable_i,
  input  wire logic [4:0]                tmr_irq_en_i,
  input  wire logic                      wake_irq_en_i,
  // Software moves the state from inside the management handler.
  input  wire logic                      state_wr_i,
  input  wire pcu_pkg::pcu_state_t       state_wdata_i,
  input  wire logic                      sys_mgmt_mode_i,
  input  wire logic                      cause_ack_i,
  // Suspend request duty per state, all four bits of each entry used.
  input  wire logic [pcu_pkg::DUTY_W-1:0] duty_on_i,
  input  wire logic [pcu_pkg::DUTY_W-1:0] duty_doze_i,
  input  wire logic [pcu_pkg::DUTY_W-1:0] duty_stby_i,
  input  wire logic [2:0]                plane_doze_i,
  input  wire logic [2:0]                plane_stby_i,
  input  wire logic [2:0]                plane_core_suspend_request_i,
  // Core handshake for suspend.
  input  wire logic                      core_idle_i,
  input  wire logic                      clock_stop_request_i,
  // I/O trap.
  input  wire logic                      io_valid_i,
  input  wire logic [15:0]               io_addr_i,
  input  wire logic [15:0]               trap_addr_i,
  input  wire logic [15:0]               trap_mask_i,
  input  wire logic                      trap_en_i,
  input  wire logic                      io_restart_i,
  input  wire logic [19:0]               mem_addr_i,
  output logic                           sys_mgmt_interrupt_o,
  output logic [6:0]                     mgmt_cause_o,
  output pcu_pkg::pcu_state_t            power_state_o,
  output logic                           core_suspend_request_o,
  output logic                           core_clocks_stopped_o,
  output logic [2:0]                     plane_en_o,
  output logic                           io_hold_o,
  output logic                           io_restart_o,
  output logic                           sys_mgmt_memory_sel_o,
  output logic                           hkp_busy_o
);
  import pcu_pkg::*;

  // Three-stage synchronisers for pin-level activity inputs.
  localparam int unsigned NPIN = 16;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] pin_d;
  logic [NPIN-1:0] pin_prev_q;

  assign pin_raw = {clock_stop_request_i, disk_act_i, serial_act_i,
                    parallel_act_i, hkp_event_i, sys_event_i};

  // A change counts only once the second and third stages agree.
  always_comb begin
    pin_d = pin_q;
    for (int i = 0; i < NPIN; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        pin_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q       <= '0;
      s2_q       <= '0;
      s3_q       <= '0;
      pin_q      <= '0;
      pin_prev_q <= '0;
    end else begin
      s1_q       <= pin_raw;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      pin_q      <= pin_d;
      pin_prev_q <= pin_q;
    end
  end

  // Rising edges mark one activity event each.
  logic [NPIN-1:0] pin_rise;
  assign pin_rise = pin_q & ~pin_prev_q;

  // Programmable detector: only unmasked system events count.
  logic sys_act;
  logic hkp_act;
  logic peri_act;
  logic clkstop_req;
  assign sys_act  = |(pin_rise[7:0] & sys_event_mask_i);
  assign hkp_act  = |pin_rise[11:8];
  assign peri_act = |pin_rise[14:12];
  assign clkstop_req = pin_q[15];

  // Timer bank: three system timers, house-keeping and peripheral.
  logic [NUM_TMR-1:0]     tmr_act;
  logic [NUM_TMR-1:0]     tmr_exp;
  logic [TMR_W-1:0]       tmr_period [NUM_TMR];
  logic [TMR_W-1:0]       tmr_cnt [NUM_TMR];
  assign tmr_act    = {peri_act, hkp_act, sys_act, sys_act, sys_act};
  assign tmr_period[TMR_DOZE] = doze_period_i;
  assign tmr_period[TMR_STBY] = standby_period_i;
  assign tmr_period[TMR_CORE_SUSPEND_REQUEST] = suspend_period_i;
  assign tmr_period[TMR_HKP]  = hkp_period_i;
  assign tmr_period[TMR_PERI] = peri_period_i;
  for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
    pcu_timer u_tmr (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .enable_i   (tmr_enable_i[g]),
      .activity_i (tmr_act[g]),
      .period_i   (tmr_period[g]),
      .expired_o  (tmr_exp[g]),
      .count_o    (tmr_cnt[g])
    );
  end
  // House-keeping bursts keep a window open without waking the system.
  assign hkp_busy_o = (tmr_cnt[TMR_HKP] != '0) &&
                      tmr_enable_i[TMR_HKP];

  // Power state register; software decides each move, hardware only reports.
  pcu_state_t state_q;
  pcu_state_t state_d;
  logic       in_pdown;

  function automatic logic is_pdown(input pcu_state_t s);
    return (s != PCU_ON);
  endfunction : is_pdown

  assign in_pdown = is_pdown(state_q);

  always_comb begin
    state_d = state_q;
    if (state_wr_i && sys_mgmt_mode_i) begin
      case (state_wdata_i)
        PCU_ON, PCU_DOZE, PCU_STANDBY, PCU_SUSPEND: begin
          state_d = state_wdata_i;
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= PCU_ON;
    end else begin
      state_q <= state_d;
    end
  end

  assign power_state_o = state_q;

  // Sticky interrupt causes; a new event wins over the acknowledge.
  // Bits: 0..4 timers, 5 wake, 6 I/O trap.
  logic [6:0] cause_q;
  logic [6:0] cause_d;
  logic [6:0] cause_set;
  logic       trap_hit;
  logic       wake_ev;
  assign wake_ev = in_pdown && sys_act && wake_irq_en_i;
  assign cause_set = {trap_hit, wake_ev,
                      tmr_exp & tmr_irq_en_i};
  always_comb begin
    cause_d = cause_q;
    if (cause_ack_i) begin
      cause_d = '0;
    end
    cause_d = cause_d | cause_set;
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_q <= '0;
    end else begin
      cause_q <= cause_d;
    end
  end
  assign mgmt_cause_o         = cause_q;
  assign sys_mgmt_interrupt_o = |cause_q;
  // I/O trap: hold the matching access until the handler restarts it.
  logic hold_q;
  logic hold_d;
  logic restart_q;
  logic restart_d;
  assign trap_hit = trap_en_i && io_valid_i && !hold_q &&
                    (((io_addr_i ^ trap_addr_i) & ~trap_mask_i) == '0);
  always_comb begin
    hold_d    = hold_q;
    restart_d = 1'b0;
    if (trap_hit) begin
      hold_d = 1'b1;
    end else if (hold_q && io_restart_i) begin
      hold_d    = 1'b0;
      restart_d = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q    <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      hold_q    <= hold_d;
      restart_q <= restart_d;
    end
  end
  assign io_hold_o    = hold_q;
  assign io_restart_o = restart_q;
  // Suspend sequencer: drain the core before clocks stop, release on exit.
  pcu_core_suspend_request_t core_suspend_request_q;
  pcu_core_suspend_request_t core_suspend_request_d;
  logic      want_stop;

  assign want_stop = (state_q == PCU_SUSPEND) || clkstop_req;

  always_comb begin
    core_suspend_request_d = core_suspend_request_q;
    case (core_suspend_request_q)
      PCU_RUN: begin
        if (want_stop) begin
          core_suspend_request_d = PCU_DRAIN;
        end
      end
      PCU_DRAIN: begin
        if (!want_stop) begin
          core_suspend_request_d = PCU_RUN;
        end else if (core_idle_i) begin
          core_suspend_request_d = PCU_HALT;
        end
      end
      PCU_HALT: begin
        if (!want_stop) begin
          core_suspend_request_d = PCU_RUN;
        end
      end
      default: begin
        core_suspend_request_d = PCU_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_suspend_request_q <= PCU_RUN;
    end else begin
      core_suspend_request_q <= core_suspend_request_d;
    end
  end

  // Clocks stop only in HALT; the static core keeps its state meanwhile.
  assign core_clocks_stopped_o = (core_suspend_request_q == PCU_HALT);

  // Duty modulation: request is asserted for duty counts out of sixteen.
  logic [DUTY_W-1:0] phase_q;
  logic [DUTY_W-1:0] phase_d;
  logic [DUTY_W-1:0] duty;
  logic              core_suspend_request_req_q;
  logic              core_suspend_request_req_d;

  always_comb begin
    case (state_q)
      PCU_ON:      duty = duty_on_i;
      PCU_DOZE:    duty = duty_doze_i;
      PCU_STANDBY: duty = duty_stby_i;
      default:     duty = duty_on_i;
    endcase
    phase_d    = phase_q + DUTY_W'(1);
    core_suspend_request_req_d = (core_suspend_request_q != PCU_RUN) || (phase_q < duty);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q    <= '0;
      core_suspend_request_req_q <= 1'b0;
    end else begin
      phase_q    <= phase_d;
      core_suspend_request_req_q <= core_suspend_request_req_d;
    end
  end

  assign core_suspend_request_o = core_suspend_request_req_q;

  // Power planes follow the state, registered to avoid glitches on supplies.
  logic [2:0] plane_q;
  logic [2:0] plane_d;

  always_comb begin
    case (state_q)
      PCU_DOZE:    plane_d = plane_doze_i;
      PCU_STANDBY: plane_d = plane_stby_i;
      PCU_SUSPEND: plane_d = plane_core_suspend_request_i;
      default:     plane_d = PLANE_RST;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      plane_q <= PLANE_RST;
    end else begin
      plane_q <= plane_d;
    end
  end
  assign plane_en_o = plane_q;
  // Management memory decode, only while the core is in management mode.
  assign sys_mgmt_memory_sel_o = sys_mgmt_mode_i &&
                                 (mem_addr_i >= MGMT_WIN_BASE) &&
                                 (mem_addr_i <= MGMT_WIN_LAST);
endmodule : pcu_power_control_unit

// >>> verilog/pcu_pkg.sv
package pcu_pkg;
  // Counter width for every inactivity timer.
  localparam int unsigned TMR_W = 16;
  // Power state codes, one-hot.
  typedef enum logic [3:0] {
    PCU_ON      = 4'h1,
    PCU_DOZE    = 4'h2,
    PCU_STANDBY = 4'h4,
    PCU_SUSPEND = 4'h8
  } pcu_state_t;
  // Suspend handshake states, one-hot.
  typedef enum logic [2:0] {
    PCU_RUN   = 3'h1,
    PCU_DRAIN = 3'h2,
    PCU_HALT  = 3'h4
  } pcu_core_suspend_request_t;
  // Number of inactivity timers handled by the generate loop.
  localparam int unsigned NUM_TMR = 5;
  localparam int unsigned TMR_DOZE = 0;
  localparam int unsigned TMR_STBY = 1;
  localparam int unsigned TMR_CORE_SUSPEND_REQUEST = 2;
  localparam int unsigned TMR_HKP  = 3;
  localparam int unsigned TMR_PERI = 4;
  // Duty counter width for suspend request modulation.
  localparam int unsigned DUTY_W = 4;
  // Reset value of the power plane enables.
  localparam logic [2:0] PLANE_RST = 3'h7;
  // Management memory window, 128K.
  localparam logic [19:0] MGMT_WIN_BASE = 20'hA0000;
  localparam logic [19:0] MGMT_WIN_LAST = 20'hBFFFF;
  localparam logic [19:0] MGMT_WIN_SIZE = 20'h20000;
  // Pin inputs pass three flip-flops.
  localparam int unsigned SYNC_N = 3;
endpackage : pcu_pkg

// >>> verilog/pcu_timer.sv
`timescale 1ns/100ps
// One inactivity down counter: reloads on activity, counts down while idle,
// and raises a one-cycle expiry pulse when it reaches zero.
module pcu_timer (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      enable_i,
  input  wire logic                      activity_i,
  input  wire logic [pcu_pkg::TMR_W-1:0] period_i,
  output logic                           expired_o,
  output logic [pcu_pkg::TMR_W-1:0]      count_o
);
  import pcu_pkg::*;

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  logic             exp_q;
  logic             exp_d;

  // Activity always reloads; the count stalls at zero so expiry fires once.
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!enable_i || activity_i) begin
      cnt_d = period_i;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - TMR_W'(1);
      exp_d = (cnt_q == TMR_W'(1));
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired_o = exp_q;
  assign count_o   = cnt_q;
endmodule : pcu_timer

// >>> test/pcu_power_control_unit_sva.sv
`timescale 1ns/100ps
// Port-level checks of the power control unit, one clock domain.
module pcu_chk (
  input wire logic                sys_clk_i,
  input wire logic                rst_i,
  input wire logic                state_wr_i,
  input wire pcu_pkg::pcu_state_t state_wdata_i,
  input wire logic                sys_mgmt_mode_i,
  input wire logic                io_valid_i,
  input wire logic [15:0]         io_addr_i,
  input wire logic [15:0]         trap_addr_i,
  input wire logic [15:0]         trap_mask_i,
  input wire logic                trap_en_i,
  input wire logic                io_restart_i,
  input wire logic [19:0]         mem_addr_i,
  input wire logic [2:0]          plane_core_suspend_request_i,
  input wire logic                sys_mgmt_interrupt_o,
  input wire logic [6:0]          mgmt_cause_o,
  input wire pcu_pkg::pcu_state_t power_state_o,
  input wire logic                core_suspend_request_o,
  input wire logic                core_clocks_stopped_o,
  input wire logic [2:0]          plane_en_o,
  input wire logic                io_hold_o,
  input wire logic                io_restart_o,
  input wire logic                sys_mgmt_memory_sel_o
);
  import pcu_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ok;
  logic hit;
  // Decodes of an accepted state write and of a trappable I/O access.
  assign wr_ok = state_wr_i && sys_mgmt_mode_i && $onehot(state_wdata_i);
  assign hit = io_valid_i && trap_en_i && !io_hold_o &&
               (((io_addr_i ^ trap_addr_i) & ~trap_mask_i) == 16'h0000);
  property p_or;
    sys_mgmt_interrupt_o == (|mgmt_cause_o);
  endproperty
  a_or: assert property (p_or)
    else $error("interrupt differs from causes");
  property p_win;
    sys_mgmt_memory_sel_o == (mem_addr_i inside {[20'hA0000:20'hBFFFF]});
  endproperty
  a_win: assert property (p_win)
    else $error("memory window decode wrong");
  property p_wr;
    wr_ok |=> power_state_o == $past(state_wdata_i);
  endproperty
  a_wr: assert property (p_wr)
    else $error("state write not taken");
  property p_keep;
    !wr_ok |=> $stable(power_state_o);
  endproperty
  a_keep: assert property (p_keep)
    else $error("state moved without write");
  property p_trap;
    hit |=> io_hold_o && mgmt_cause_o[6];
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap not held");
  property p_rs;
    io_hold_o && io_restart_i |=> !io_hold_o && io_restart_o ##1 !io_restart_o;
  endproperty
  a_rs: assert property (p_rs)
    else $error("restart sequence wrong");
  property p_core_suspend_request;
    power_state_o == PCU_SUSPEND |-> ##[1:3] core_suspend_request_o;
  endproperty
  a_core_suspend_request: assert property (p_core_suspend_request)
    else $error("no suspend request in suspend");
  property p_stop;
    core_clocks_stopped_o |-> core_suspend_request_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("clocks stopped without request");
  property p_pl;
    $stable(power_state_o) && power_state_o == PCU_SUSPEND |->
      plane_en_o == plane_core_suspend_request_i;
  endproperty
  a_pl: assert property (p_pl)
    else $error("planes wrong in suspend");
endmodule : pcu_chk
bind pcu_power_control_unit pcu_chk chk (.*);

// >>> test/pcu_core_model.sv
`timescale 1ns/100ps
// Core seen from the unit: it drains its pipeline for a while after a
// suspend request, then reports idle; slow models a long bus cycle.
module pcu_core_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic req_i,
  output logic      idle_o
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  // Drain count restarts when the request drops, so fetch resumes at once.
  always_comb begin
    cnt_d = 4'h0;
    if (req_i && cnt_q != 4'hF) begin
      cnt_d = cnt_q + 4'h1;
    end else if (req_i) begin
      cnt_d = cnt_q;
    end
  end
  // Registered count.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign idle_o = req_i && (cnt_q >= (slow_i ? 4'hC : 4'h2));
endmodule : pcu_core_model

// >>> test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pcu_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  sys_event_i = 8'h00;
  logic [7:0]  sys_event_mask_i = 8'h01;
  logic [3:0]  hkp_event_i = 4'h0;
  logic        disk_act_i = 1'b0;
  logic        serial_act_i = 1'b0;
  logic        parallel_act_i = 1'b0;
  logic [15:0] doze_period_i = 16'h0014;
  logic [15:0] standby_period_i = 16'h0028;
  logic [15:0] suspend_period_i = 16'h003C;
  logic [15:0] hkp_period_i = 16'h005A;
  logic [15:0] peri_period_i = 16'h006E;
  logic [4:0]  tmr_enable_i = 5'h00;
  logic [4:0]  tmr_irq_en_i = 5'h1F;
  logic        wake_irq_en_i = 1'b0;
  logic        state_wr_i = 1'b0;
  pcu_state_t  state_wdata_i = PCU_ON;
  logic        sys_mgmt_mode_i = 1'b1;
  logic        cause_ack_i = 1'b0;
  logic [3:0]  duty_on_i = 4'h0;
  logic [3:0]  duty_doze_i = 4'h4;
  logic [3:0]  duty_stby_i = 4'h8;
  logic [2:0]  plane_doze_i = 3'h3;
  logic [2:0]  plane_stby_i = 3'h1;
  logic [2:0]  plane_core_suspend_request_i = 3'h0;
  logic        clock_stop_request_i = 1'b0;
  logic        io_valid_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic [15:0] trap_addr_i = 16'h0060;
  logic [15:0] trap_mask_i = 16'h0003;
  logic        trap_en_i = 1'b1;
  logic        io_restart_i = 1'b0;
  logic [19:0] mem_addr_i = 20'h00000;
  logic        slow = 1'b0;
  logic        core_idle_i, sys_mgmt_interrupt_o, core_suspend_request_o;
  logic        core_clocks_stopped_o, io_hold_o, io_restart_o;
  logic        sys_mgmt_memory_sel_o, hkp_busy_o;
  logic [6:0]  mgmt_cause_o;
  logic [2:0]  plane_en_o;
  pcu_state_t  power_state_o;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          hi;
  pcu_state_t  st [4] = '{PCU_DOZE, PCU_STANDBY, PCU_SUSPEND, PCU_ON};
  logic [2:0]  pl [4] = '{3'h3, 3'h1, 3'h0, 3'h7};
  logic [19:0] wa [4] = '{20'h9FFFF, 20'hA0000, 20'hBFFFF, 20'hC0000};

  pcu_core_model core (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .slow_i    (slow),
    .req_i     (core_suspend_request_o),
    .idle_o    (core_idle_i)
  );
  pcu_power_control_unit dut (.*);

  // Free-running 100 MHz clock.
  always #5 sys_clk_i = ~sys_clk_i;

  // Steps end at a falling edge, where registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc

  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  // Software state write from inside the management handler.
  task automatic set_st(input pcu_state_t s);
    @(posedge sys_clk_i);
    state_wr_i    <= 1'b1;
    state_wdata_i <= s;
    @(posedge sys_clk_i);
    state_wr_i <= 1'b0;
    cyc(2);
  endtask : set_st

  // Activity held two cycles: a one-cycle pulse never lets the second and
  // third synchroniser stages agree, so the unit would not see it.
  task automatic sev(input logic [7:0] s, input logic [3:0] h);
    @(posedge sys_clk_i);
    sys_event_i <= s;
    hkp_event_i <= h;
    disk_act_i  <= s[0];
    repeat (2) @(posedge sys_clk_i);
    sys_event_i <= 8'h00;
    hkp_event_i <= 4'h0;
    disk_act_i  <= 1'b0;
    cyc(10);
  endtask : sev

  task automatic ack;
    @(posedge sys_clk_i);
    cause_ack_i <= 1'b1;
    @(posedge sys_clk_i);
    cause_ack_i <= 1'b0;
    cyc(1);
    chk("cause", 7'h00, mgmt_cause_o);
  endtask : ack

  task automatic summarize;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Watchdog; the whole sequence needs well under a thousand cycles.
  initial begin
    cyc(3000);
    n_errors++;
    summarize();
  end

  initial begin
    cyc(5);
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk("state", PCU_ON, power_state_o);
    chk("plane", 3'h7, plane_en_o);
    foreach (st[i]) begin
      set_st(st[i]);
      chk("state", st[i], power_state_o);
      chk("plane", pl[i], plane_en_o);
    end
    @(posedge sys_clk_i);
    sys_mgmt_mode_i <= 1'b0;
    set_st(PCU_DOZE);
    @(posedge sys_clk_i);
    sys_mgmt_mode_i <= 1'b1;
    set_st(pcu_state_t'(4'h3));
    chk("state", PCU_ON, power_state_o);
    // Suspend with a prompt core, then with a slow one.
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_i);
      slow <= i[0];
      set_st(PCU_SUSPEND);
      hi = 0;
      while (core_clocks_stopped_o !== 1'b1 && hi < 40) begin
        cyc(1);
        hi++;
      end
      chk("stopped", 1'b1, core_clocks_stopped_o);
      set_st(PCU_ON);
      cyc(2);
      chk("stopped", 1'b0, core_clocks_stopped_o);
    end
    // Clock-stop pin drains and stops the core while the state stays On.
    @(posedge sys_clk_i);
    clock_stop_request_i <= 1'b1;
    cyc(30);
    chk("stopped", 1'b1, core_clocks_stopped_o);
    chk("state", PCU_ON, power_state_o);
    @(posedge sys_clk_i);
    clock_stop_request_i <= 1'b0;
    cyc(8);
    chk("stopped", 1'b0, core_clocks_stopped_o);
    // Duty of the suspend request while fully on.
    for (int d = 0; d < 2; d++) begin
      @(posedge sys_clk_i);
      duty_on_i <= d[0] ? 4'h8 : 4'h0;
      cyc(4);
      hi = 0;
      repeat (32) begin
        cyc(1);
        hi += int'(core_suspend_request_o);
      end
      chk("duty", d[0] ? 20'h00010 : 20'h00000, hi);
    end
    // Activity every 12 cycles keeps the 20-cycle doze timer reloaded.
    @(posedge sys_clk_i);
    tmr_enable_i <= 5'h01;
    repeat (6) sev(8'h01, 4'h0);
    chk("cause", 7'h00, mgmt_cause_o);
    cyc(30);
    chk("cause", 7'h01, mgmt_cause_o);
    chk("smi", 1'b1, sys_mgmt_interrupt_o);
    ack();
    set_st(PCU_DOZE);
    @(posedge sys_clk_i);
    tmr_enable_i <= 5'h1E;
    tmr_irq_en_i <= 5'h1D;
    cyc(30);
    chk("cause", 7'h00, mgmt_cause_o);
    cyc(45);
    chk("cause", 7'h04, mgmt_cause_o);
    cyc(50);
    chk("cause", 7'h1C, mgmt_cause_o);
    chk("hkp busy", 1'b0, hkp_busy_o);
    ack();
    sev(8'h00, 4'h1);
    chk("state", PCU_DOZE, power_state_o);
    chk("hkp busy", 1'b1, hkp_busy_o);
    sev(8'h01, 4'h0);
    chk("cause", 7'h00, mgmt_cause_o);
    @(posedge sys_clk_i);
    wake_irq_en_i <= 1'b1;
    sev(8'h02, 4'h0);
    chk("cause", 7'h00, mgmt_cause_o);
    sev(8'h01, 4'h0);
    chk("cause", 7'h20, mgmt_cause_o);
    ack();
    // A near miss, then a hit inside the masked range.
    @(posedge sys_clk_i);
    io_valid_i <= 1'b1;
    io_addr_i  <= 16'h0070;
    cyc(2);
    chk("hold", 1'b0, io_hold_o);
    @(posedge sys_clk_i);
    io_addr_i <= 16'h0062;
    @(posedge sys_clk_i);
    io_valid_i <= 1'b0;
    cyc(1);
    chk("cause", 7'h40, mgmt_cause_o);
    chk("hold", 1'b1, io_hold_o);
    @(posedge sys_clk_i);
    io_restart_i <= 1'b1;
    @(posedge sys_clk_i);
    io_restart_i <= 1'b0;
    cyc(1);
    chk("restart", 1'b1, io_restart_o);
    chk("hold", 1'b0, io_hold_o);
    foreach (wa[i]) begin
      @(posedge sys_clk_i);
      mem_addr_i <= wa[i];
      cyc(1);
      chk("window", i == 1 || i == 2, sys_mgmt_memory_sel_o);
    end
    summarize();
  end
endmodule : tb_top
